/* rtl/sensor_cfg_irq_routing.sv */
`timescale 1ns/1ns
module sensor_cfg_irq_routing (
  input  wire logic                      clk_i,
  input  wire logic                      resetn_i,
  input  wire sensor_cfg_pkg::reg_req_t  req_i,
  output logic [7:0]                     rdata_o,
  output logic                           rvalid_o,
  input  wire sensor_cfg_pkg::irq_src_t  irq_src_i,
  input  wire logic                      aux_default_i,
  input  wire logic [3:0]                gain_ceiling_i,
  input  wire logic                      meas_done_i,
  input  wire logic                      analog_sat_i,
  input  wire logic                      agc_start_i,
  output logic                           irq_pin_o,
  output logic                           aux_pin_o,
  output logic [3:0]                     light_gain_o,
  output logic                           agc_busy_o,
  output logic                           agc_enable_o,
  output logic                           parallel_sense_o,
  output logic                           use_near_sample_time_o,
  output logic                           ir_diode_to_fifth_light_path_o
);
  import sensor_cfg_pkg::*;

  // ****************************************
  // Registers
  // ****************************************
  logic [7:0] pin_route_cfg_reg;
  logic [7:0] gain_search_cfg_reg;
  logic [7:0] engine_mode_cfg_reg;

  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      pin_route_cfg_reg   <= PIN_ROUTE_CFG_RST;
      gain_search_cfg_reg <= GAIN_SEARCH_CFG_RST;
      engine_mode_cfg_reg <= ENGINE_MODE_CFG_RST;
    end else if (req_i.we) begin
      case (req_i.addr)
        PIN_ROUTE_CFG_OFF: begin
          pin_route_cfg_reg <= (req_i.wdata & PIN_ROUTE_CFG_WMASK)
                             | (PIN_ROUTE_CFG_RST & ~PIN_ROUTE_CFG_WMASK);
        end
        GAIN_SEARCH_CFG_OFF: begin
          gain_search_cfg_reg <= (req_i.wdata & GAIN_SEARCH_CFG_WMASK)
                               | (GAIN_SEARCH_CFG_RST & ~GAIN_SEARCH_CFG_WMASK);
        end
        ENGINE_MODE_CFG_OFF: begin
          engine_mode_cfg_reg <= (req_i.wdata & ENGINE_MODE_CFG_WMASK)
                               | (ENGINE_MODE_CFG_RST & ~ENGINE_MODE_CFG_WMASK);
        end
        default: begin
        end
      endcase
    end
  end

  // Reads answer one cycle later; unmapped reads give zero
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      rdata_o  <= 8'h00;
      rvalid_o <= 1'b0;
    end else begin
      rvalid_o <= req_i.re;
      case (req_i.addr)
        PIN_ROUTE_CFG_OFF:   rdata_o <= pin_route_cfg_reg;
        GAIN_SEARCH_CFG_OFF: rdata_o <= gain_search_cfg_reg;
        ENGINE_MODE_CFG_OFF: rdata_o <= engine_mode_cfg_reg;
        default:             rdata_o <= 8'h00;
      endcase
    end
  end

  // ****************************************
  // Pin routing
  // ****************************************
  logic [2:0] irq_pin_source_select;
  logic [2:0] aux_pin_source_select;
  logic       irq_invert;
  logic       irq_active;
  logic       aux_level;

  assign irq_pin_source_select = pin_route_cfg_reg[IRQ_SEL_LSB +: 3];
  assign aux_pin_source_select = pin_route_cfg_reg[AUX_SEL_LSB +: 3];
  assign irq_invert            = pin_route_cfg_reg[IRQ_INVERT_BIT];

  always_comb begin
    case (irq_pin_source_select) // [RQ1]
      SEL_NORMAL: irq_active = irq_src_i.normal;
      SEL_LIGHT:  irq_active = irq_src_i.light;
      SEL_NEAR_A: irq_active = irq_src_i.near_a;
      SEL_NEAR_B: irq_active = irq_src_i.near_b;
      default:    irq_active = 1'b0; // Reserved codes never assert
    endcase
  end

  always_comb begin
    case (aux_pin_source_select) // [RQ3]
      SEL_NORMAL: aux_level = aux_default_i;
      SEL_LIGHT:  aux_level = irq_src_i.light;
      SEL_NEAR_A: aux_level = irq_src_i.near_a;
      SEL_NEAR_B: aux_level = irq_src_i.near_b;
      default:    aux_level = 1'b0;
    endcase
  end

  // Pin idles high after reset: inactive level without inversion
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      irq_pin_o <= 1'b1;
      aux_pin_o <= 1'b0;
    end else begin
      irq_pin_o <= irq_invert ? irq_active : ~irq_active; // [RQ2] [RQ10]
      aux_pin_o <= aux_level;
    end
  end

  // ****************************************
  // Mode outputs
  // ****************************************
  logic parallel_sense;
  logic swap_phase_reg;
  assign parallel_sense = engine_mode_cfg_reg[PARALLEL_BIT];

  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      parallel_sense_o               <= 1'b0;
      use_near_sample_time_o         <= 1'b0;
      agc_enable_o                   <= 1'b0;
      ir_diode_to_fifth_light_path_o <= 1'b0;
    end else begin
      parallel_sense_o       <= parallel_sense;  // [RQ6]
      use_near_sample_time_o <= parallel_sense;  // [RQ6]
      agc_enable_o           <= engine_mode_cfg_reg[AGC_EN_BIT]; // [RQ7]
      // Swap only after the proximity measurement of a serial cycle
      ir_diode_to_fifth_light_path_o <= engine_mode_cfg_reg[SWAP_BIT]
                                        & ~parallel_sense & swap_phase_reg; // [RQ8] [RQ9]
    end
  end

  // Serial cycle phase: proximity first, then light phase owns the diode
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      swap_phase_reg <= 1'b0;
    end else if (parallel_sense || !engine_mode_cfg_reg[SWAP_BIT]) begin
      swap_phase_reg <= 1'b0;
    end else if (meas_done_i) begin
      swap_phase_reg <= ~swap_phase_reg; // [RQ9]
    end
  end

  // ****************************************
  // Gain search
  // ****************************************
  typedef enum logic [1:0] {
    AGC_IDLE   = 2'b01,
    AGC_SEARCH = 2'b10
  } agc_state_t;

  agc_state_t agc_state_reg;
  logic [3:0] gain_reg;

  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      agc_state_reg <= AGC_IDLE;
      gain_reg      <= GAIN_MIN;
    end else begin
      case (agc_state_reg)
        AGC_IDLE: begin
          if (agc_start_i && engine_mode_cfg_reg[AGC_EN_BIT]) begin // [RQ7]
            if (gain_search_cfg_reg[TOP_GAIN_BIT]) begin
              gain_reg      <= gain_ceiling_i; // [RQ4]
              agc_state_reg <= AGC_SEARCH;
            end
          end
        end
        AGC_SEARCH: begin
          if (!engine_mode_cfg_reg[AGC_EN_BIT]) begin
            agc_state_reg <= AGC_IDLE;
          end else if (meas_done_i) begin
            if (!analog_sat_i || gain_reg == GAIN_MIN) begin // [RQ5]
              agc_state_reg <= AGC_IDLE;
            end else begin
              gain_reg <= gain_reg - 4'h1; // [RQ5]
            end
          end
        end
        default: agc_state_reg <= AGC_IDLE;
      endcase
    end
  end

  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      light_gain_o <= GAIN_MIN;
      agc_busy_o   <= 1'b0;
    end else begin
      light_gain_o <= gain_reg;
      agc_busy_o   <= (agc_state_reg == AGC_SEARCH);
    end
  end

  // ****************************************
  // Checks
  // ****************************************
  irq_route_low_a: assert property (@(posedge clk_i) disable iff (!resetn_i) // [RQ10]
    (!irq_invert && irq_pin_source_select == SEL_LIGHT && irq_src_i.light)
      |=> !irq_pin_o)
    else $error("irq pin not low for active light irq");
  irq_invert_high_a: assert property (@(posedge clk_i) disable iff (!resetn_i) // [RQ2]
    (irq_invert && irq_pin_source_select == SEL_NEAR_A && irq_src_i.near_a)
      |=> irq_pin_o)
    else $error("inverted irq pin not high");
  irq_select_b_a: assert property (@(posedge clk_i) disable iff (!resetn_i) // [RQ1]
    (!irq_invert && irq_pin_source_select == SEL_NEAR_B) |=> irq_pin_o == !$past(irq_src_i.near_b))
    else $error("irq pin does not follow near b");
  aux_select_a: assert property (@(posedge clk_i) disable iff (!resetn_i) // [RQ3]
    (aux_pin_source_select == SEL_NORMAL) |=> aux_pin_o == $past(aux_default_i))
    else $error("aux pin does not follow default");
  agc_top_start_a: assert property (@(posedge clk_i) disable iff (!resetn_i) // [RQ4]
    (agc_state_reg == AGC_IDLE && agc_start_i && engine_mode_cfg_reg[AGC_EN_BIT]
     && gain_search_cfg_reg[TOP_GAIN_BIT]) |=> ##1 light_gain_o == $past(gain_ceiling_i, 2))
    else $error("gain search did not start at ceiling");
  agc_step_down_a: assert property (@(posedge clk_i) disable iff (!resetn_i) // [RQ5]
    (agc_state_reg == AGC_SEARCH && engine_mode_cfg_reg[AGC_EN_BIT] && meas_done_i
     && analog_sat_i && gain_reg != GAIN_MIN) |=> gain_reg == $past(gain_reg) - 4'h1)
    else $error("gain did not step down");
  agc_stop_a: assert property (@(posedge clk_i) disable iff (!resetn_i) // [RQ5]
    (agc_state_reg == AGC_SEARCH && meas_done_i && !analog_sat_i)
      |=> agc_state_reg == AGC_IDLE ##1 !agc_busy_o)
    else $error("gain search did not stop");
  swap_gate_a: assert property (@(posedge clk_i) disable iff (!resetn_i) // [RQ8]
    parallel_sense |=> !ir_diode_to_fifth_light_path_o)
    else $error("swap active in parallel mode");
  parallel_out_a: assert property (@(posedge clk_i) disable iff (!resetn_i) // [RQ6]
    ##1 use_near_sample_time_o == $past(parallel_sense))
    else $error("parallel sense output stale");
  parallel_mode_a: assert property (@(posedge clk_i) disable iff (!resetn_i) // [RQ6]
    ##1 parallel_sense_o == $past(parallel_sense))
    else $error("parallel mode output stale");

  // ****************************************
  // Routing checks
  // ****************************************
  irq_normal_a: assert property (@(posedge clk_i) disable iff (!resetn_i) // [RQ1] [RQ10]
    (!irq_invert && irq_pin_source_select == SEL_NORMAL)
      |=> irq_pin_o == !$past(irq_src_i.normal))
    else $error("irq pin does not follow combined irq");
  irq_invert_light_a: assert property (@(posedge clk_i) disable iff (!resetn_i) // [RQ2]
    (irq_invert && irq_pin_source_select == SEL_LIGHT)
      |=> irq_pin_o == $past(irq_src_i.light))
    else $error("inverted irq pin does not follow light irq");
  aux_light_a: assert property (@(posedge clk_i) disable iff (!resetn_i) // [RQ3]
    (aux_pin_source_select == SEL_LIGHT) |=> aux_pin_o == $past(irq_src_i.light))
    else $error("aux pin does not follow light irq");
  aux_first_near_a: assert property (@(posedge clk_i) disable iff (!resetn_i) // [RQ3]
    (aux_pin_source_select == SEL_NEAR_A) |=> aux_pin_o == $past(irq_src_i.near_a))
    else $error("aux pin does not follow near a");
  aux_second_near_a: assert property (@(posedge clk_i) disable iff (!resetn_i) // [RQ3]
    (aux_pin_source_select == SEL_NEAR_B) |=> aux_pin_o == $past(irq_src_i.near_b))
    else $error("aux pin does not follow near b");

  // ****************************************
  // Gain checks
  // ****************************************
  agc_enable_out_a: assert property (@(posedge clk_i) disable iff (!resetn_i) // [RQ7]
    ##1 agc_enable_o == $past(engine_mode_cfg_reg[AGC_EN_BIT]))
    else $error("gain control enable output stale");
  agc_hold_idle_a: assert property (@(posedge clk_i) disable iff (!resetn_i) // [RQ7]
    (agc_state_reg == AGC_IDLE && !engine_mode_cfg_reg[AGC_EN_BIT])
      |=> agc_state_reg == AGC_IDLE)
    else $error("gain search started while disabled");
  agc_floor_stop_a: assert property (@(posedge clk_i) disable iff (!resetn_i) // [RQ5]
    (agc_state_reg == AGC_SEARCH && meas_done_i && gain_reg == GAIN_MIN)
      |=> agc_state_reg == AGC_IDLE && gain_reg == GAIN_MIN)
    else $error("gain search did not stop at lowest gain");
  agc_gain_out_a: assert property (@(posedge clk_i) disable iff (!resetn_i) // [RQ4]
    ##1 light_gain_o == $past(gain_reg))
    else $error("light gain output stale");
  agc_busy_out_a: assert property (@(posedge clk_i) disable iff (!resetn_i) // [RQ5]
    ##1 agc_busy_o == ($past(agc_state_reg) == AGC_SEARCH))
    else $error("busy output does not follow search");

  // ****************************************
  // Swap checks
  // ****************************************
  swap_light_phase_a: assert property (@(posedge clk_i) disable iff (!resetn_i) // [RQ9]
    (engine_mode_cfg_reg[SWAP_BIT] && !parallel_sense && swap_phase_reg)
      |=> ir_diode_to_fifth_light_path_o)
    else $error("diode not joined in light phase");
  swap_near_first_a: assert property (@(posedge clk_i) disable iff (!resetn_i) // [RQ9]
    !swap_phase_reg |=> !ir_diode_to_fifth_light_path_o)
    else $error("diode joined during proximity phase");
  swap_phase_step_a: assert property (@(posedge clk_i) disable iff (!resetn_i) // [RQ9]
    (engine_mode_cfg_reg[SWAP_BIT] && !parallel_sense && meas_done_i)
      |=> swap_phase_reg != $past(swap_phase_reg))
    else $error("serial phase did not advance");

  agc_search_c: cover property (@(posedge clk_i) disable iff (!resetn_i)
    agc_state_reg == AGC_SEARCH && meas_done_i && gain_reg == GAIN_MIN);
  swap_c: cover property (@(posedge clk_i) disable iff (!resetn_i)
    ir_diode_to_fifth_light_path_o);
  invert_c: cover property (@(posedge clk_i) disable iff (!resetn_i)
    irq_invert && irq_pin_o);
  agc_step_c: cover property (@(posedge clk_i) disable iff (!resetn_i)
    agc_state_reg == AGC_SEARCH && meas_done_i && analog_sat_i && gain_reg != GAIN_MIN);
  aux_route_c: cover property (@(posedge clk_i) disable iff (!resetn_i)
    aux_pin_source_select == SEL_NEAR_B && aux_pin_o);

endmodule // sensor_cfg_irq_routing

/* rtl/sensor_cfg_pkg.sv */
// Functional notes
// [RQ1] Interrupt pin select: 0 combined, 1 reserved, 2 light, 3 near A, 4 near B.
// [RQ2] Polarity flip set drives the interrupt pin high while active.
// [RQ3] Aux pin select: 0 default, 1 reserved, 2 light, 3 near A, 4 near B.
// [RQ4] Top-gain-first set starts gain search at the configured gain ceiling.
// [RQ5] Search steps gain down until no analog saturation or gain code 0.
// [RQ6] Parallel-sense set times cycles from near sample time, runs both concurrently.
// [RQ7] Auto-gain enable lets light engines adjust gain automatically; the code only starts a search while top-gain-first is also set.
// [RQ8] Diode swap works only while parallel-sense is clear.
// [RQ9] Swap: proximity measurement first, then diode joins fifth light engine.
// [RQ10] Without polarity flip the interrupt pin is low while active.
// [RQ11] Host writes reserved fields with reset values, never select code 1.
package sensor_cfg_pkg;

  localparam logic [7:0] PIN_ROUTE_CFG_OFF   = 8'h00ad;
  localparam logic [7:0] GAIN_SEARCH_CFG_OFF = 8'h00af;
  localparam logic [7:0] ENGINE_MODE_CFG_OFF = 8'h00b1;

  localparam logic [7:0] PIN_ROUTE_CFG_RST   = 8'h0000;
  localparam logic [7:0] GAIN_SEARCH_CFG_RST = 8'h0000;
  localparam logic [7:0] ENGINE_MODE_CFG_RST = 8'h0080;

  // Writable bit masks; other bits keep reset value
  localparam logic [7:0] PIN_ROUTE_CFG_WMASK   = 8'h007f;
  localparam logic [7:0] GAIN_SEARCH_CFG_WMASK = 8'h0040;
  localparam logic [7:0] ENGINE_MODE_CFG_WMASK = 8'h0016;

  localparam int IRQ_SEL_LSB    = 4;
  localparam int IRQ_INVERT_BIT = 3;
  localparam int AUX_SEL_LSB    = 0;
  localparam int TOP_GAIN_BIT   = 6;
  localparam int PARALLEL_BIT   = 4;
  localparam int AGC_EN_BIT     = 2;
  localparam int SWAP_BIT       = 1;

  localparam logic [2:0] SEL_NORMAL  = 3'h0;
  localparam logic [2:0] SEL_LIGHT   = 3'h2;
  localparam logic [2:0] SEL_NEAR_A  = 3'h3;
  localparam logic [2:0] SEL_NEAR_B  = 3'h4;

  localparam logic [3:0] GAIN_MIN = 4'h0;

  typedef struct packed {
    logic normal;
    logic light;
    logic near_a;
    logic near_b;
  } irq_src_t;

  typedef struct packed {
    logic       we;
    logic       re;
    logic [7:0] addr;
    logic [7:0] wdata;
  } reg_req_t;

endpackage

/* test/meas_engine_model.sv */
`timescale 1ns/1ns
module meas_engine_model (
  input  wire logic       clk_i,
  input  wire logic       resetn_i,
  input  wire logic [3:0] gain_i,
  input  wire logic [3:0] sat_limit_i,
  output logic            done_o,
  output logic            sat_o
);
  logic [1:0] cnt_reg;
  // Saturation flag is junk outside done, as on real engines
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      cnt_reg <= 2'h0;
      done_o  <= 1'b0;
      sat_o   <= 1'b0;
    end else begin
      cnt_reg <= cnt_reg + 2'h1;
      done_o  <= (cnt_reg == 2'h3);
      sat_o   <= (cnt_reg == 2'h3) ? (gain_i > sat_limit_i) : ~sat_o;
    end
  end
endmodule // meas_engine_model

/* test/tb.sv */
`timescale 1ns/1ns
module tb;
  import sensor_cfg_pkg::*;
  logic       clk_i = 1'b0, resetn_i = 1'b0, aux_default_i = 1'b0, agc_start_i = 1'b0;
  reg_req_t   req_i = '0;
  irq_src_t   irq_src_i = '0;
  logic [3:0] gain_ceiling_i = 4'h0, sat_limit = 4'h0, light_gain_o;
  logic [7:0] rdata_o;
  logic       meas_done_i, analog_sat_i, rvalid_o, irq_pin_o, aux_pin_o, agc_busy_o;
  logic       agc_enable_o, parallel_sense_o, use_near_sample_time_o, ir_o;
  int         fail_count = 0, checked = 0, seed = 37311, n, hi;
  logic [2:0] si, sa;
  logic       inv;
  always #20 clk_i = ~clk_i;
  sensor_cfg_irq_routing dut (.clk_i(clk_i), .resetn_i(resetn_i), .req_i(req_i),
    .rdata_o(rdata_o), .rvalid_o(rvalid_o), .irq_src_i(irq_src_i),
    .aux_default_i(aux_default_i), .gain_ceiling_i(gain_ceiling_i),
    .meas_done_i(meas_done_i), .analog_sat_i(analog_sat_i), .agc_start_i(agc_start_i),
    .irq_pin_o(irq_pin_o), .aux_pin_o(aux_pin_o), .light_gain_o(light_gain_o),
    .agc_busy_o(agc_busy_o), .agc_enable_o(agc_enable_o),
    .parallel_sense_o(parallel_sense_o), .use_near_sample_time_o(use_near_sample_time_o),
    .ir_diode_to_fifth_light_path_o(ir_o));
  meas_engine_model eng (.clk_i(clk_i), .resetn_i(resetn_i), .gain_i(light_gain_o),
    .sat_limit_i(sat_limit), .done_o(meas_done_i), .sat_o(analog_sat_i));
  task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string msg);
    checked++;
    if (got !== exp) begin
      fail_count++;
      $display("MISMATCH t=%0t %s got %h exp %h", $time, msg, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_i) req_i <= '{we:1'b1, re:1'b0, addr:a, wdata:d};
    @(posedge clk_i) req_i <= '0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    @(posedge clk_i) req_i <= '{we:1'b0, re:1'b1, addr:a, wdata:8'h00};
    @(posedge clk_i) req_i <= '0;
    #1 chk({7'h0, rvalid_o}, 8'h01, "read valid");
    chk(rdata_o, exp, "read data");
  endtask
  function automatic logic pick(input logic [2:0] s, input irq_src_t x, input logic d);
    case (s)
      3'h0: return d;
      3'h2: return x.light;
      3'h3: return x.near_a;
      3'h4: return x.near_b;
      default: return 1'b0;
    endcase
  endfunction
  task automatic test_done;
    $display("checked=%0d fail_count=%0d", checked, fail_count);
    if (fail_count == 0 && checked > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  // ****************************************
  // Main sequence
  // ****************************************
  initial begin
    repeat (20) @(posedge clk_i);
    resetn_i <= 1'b1;
    rd(8'had, 8'h00);
    rd(8'haf, 8'h00);
    rd(8'hb1, 8'h80);
    wr(8'had, 8'hff);
    wr(8'haf, 8'hff);
    wr(8'hb1, 8'hff);
    rd(8'had, 8'h7f);
    rd(8'haf, 8'h40);
    rd(8'hb1, 8'h96);
    rd(8'hb0, 8'h00);
    chk({5'h0, agc_enable_o, parallel_sense_o, use_near_sample_time_o}, 8'h07, "mode");
    $display("test registers done");
    for (int i = 0; i < 48; i++) begin
      si = 3'(i);
      sa = 3'(i + 3);
      if (si == 3'h1 || sa == 3'h1) continue;
      inv = 1'($random(seed));
      wr(8'had, {1'b0, si, inv, sa});
      @(posedge clk_i) begin
        irq_src_i <= 4'($random(seed));
        aux_default_i <= 1'($random(seed));
      end
      repeat (2) @(posedge clk_i);
      #1 chk({7'h0, irq_pin_o}, {7'h0, inv ^ ~pick(si, irq_src_i, irq_src_i.normal)},
             "irq pin");
      chk({7'h0, aux_pin_o}, {7'h0, pick(sa, irq_src_i, aux_default_i)}, "aux pin");
    end
    $display("test routing done");
    wr(8'hb1, 8'h04);
    for (int t = 0; t < 8; t++) begin
      // Start just after a done, so no done taken at a stale gain reaches the search
      n = 0;
      do begin
        @(posedge clk_i);
        #1 n++;
      end while (n < 8 && meas_done_i !== 1'b1);
      if (meas_done_i !== 1'b1) begin
        fail_count++;
        $display("MISMATCH t=%0t no measurement done", $time);
      end
      @(posedge clk_i) begin
        gain_ceiling_i <= (t == 0) ? 4'hf : 4'($random(seed));
        sat_limit <= (t == 0) ? 4'h0 : 4'($random(seed));
        agc_start_i <= 1'b1;
      end
      @(posedge clk_i) agc_start_i <= 1'b0;
      @(posedge clk_i) #1 chk({4'h0, light_gain_o}, {4'h0, gain_ceiling_i}, "start gain");
      chk({7'h0, agc_busy_o}, 8'h01, "busy");
      for (n = 0; n < 300 && agc_busy_o === 1'b1; n++) begin
        @(posedge clk_i);
        #1;
      end
      if (n == 300) begin
        fail_count++;
        $display("MISMATCH t=%0t gain search hung", $time);
        test_done();
      end
      #1 chk({4'h0, light_gain_o}, {4'h0, (gain_ceiling_i < sat_limit) ? gain_ceiling_i
             : sat_limit}, "end gain");
    end
    $display("test gain search done");
    for (int m = 0; m < 2; m++) begin
      wr(8'hb1, m ? 8'h12 : 8'h02);
      hi = 0;
      repeat (40) begin
        @(posedge clk_i);
        #1 hi += (ir_o === 1'b1);
      end
      chk({7'h0, hi > 0 && hi < 40}, {7'h0, m == 0}, "diode swap");
    end
    $display("test diode swap done");
    test_done();
  end
endmodule // tb
